// ---- hw/irq_bank_pkg.sv ----
// package of constants and types for the interrupt enable and flag bank
//
// Summary of operation
// - bit 7 of core control is the global enable gating every request to the core.
// - bit 6 gates all peripheral interrupts together with each source's own enable.
// - bit 5 of core control enables the timer-0 overflow interrupt.
// - bit 4 of core control enables the external pin edge interrupt.
// - bit 3 enables pin-change interrupt; per-pin mask must also be enabled.
// - bit 2 sets on timer-0 rollover and stays set until software clears it.
// - bit 1 sets on selected external pin edge, held until software clears.
// - bit 0 sets when any of port pins 5..0 whose mask bit is set changes; held until cleared.
// - flags set on their condition regardless of any enable bit.
// - peripheral enables at bits 6,5,4,3,1,0; bits 7 and 2 read zero.
// - bit 6 of peripheral flags sets when a conversion completes.
// - bit 5 sets on capture or compare match; unused in PWM mode.
// - bits 4 and 3 set on comparator 2 and 1 output change; held.
// - bit 1 sets on timer-2 count matching its period; held until cleared.
// - bit 0 sets on timer-1 overflow; held until software clears it.
// - reduced variant: conversion, capture/compare, timer-2 bits read zero.
// - timer-0 count is untouched by reset; software loads it before clearing flag.
// - core control bits are read/write and reset to zero.
// - external pin edge is rising when edge select is 1, falling when 0.
package irq_bank_pkg;
   localparam logic [31:0] CORE_CTRL_OFS = 32'h0000_0000;
   localparam logic [31:0] PERIPH_EN_OFS = 32'h0000_0004;
   localparam logic [31:0] PERIPH_FLAG_OFS = 32'h0000_0008;
   localparam logic [31:0] PIN_MASK_OFS = 32'h0000_000C;
   localparam logic [31:0] OPTIONS_OFS = 32'h0000_0010;
   localparam logic [7:0] CORE_CTRL_RST = 8'h00;
   localparam logic [7:0] PERIPH_RST = 8'h00;
   localparam logic [5:0] PIN_MASK_RST = 6'h00;
   localparam logic EDGE_SEL_RST = 1'b1;
   localparam logic [7:0] PERIPH_IMPL_FULL = 8'h7B;
   localparam logic [7:0] PERIPH_IMPL_REDUCED = 8'h18 | 8'h01;
   localparam int GLOBAL_BIT = 7;
   localparam int GROUP_BIT = 6;
   localparam int T0_EN_BIT = 5;
   localparam int EXT_EN_BIT = 4;
   localparam int PORT_EN_BIT = 3;
   localparam int T0_FLAG_BIT = 2;
   localparam int EXT_FLAG_BIT = 1;
   localparam int PORT_FLAG_BIT = 0;
   localparam int ADC_BIT = 6;
   localparam int CAPCOMP_BIT = 5;
   localparam int CMP2_BIT = 4;
   localparam int CMP1_BIT = 3;
   localparam int TMR2_BIT = 1;
   localparam int TMR1_BIT = 0;
   localparam int EDGE_SEL_BIT = 0;
   localparam int PORT_PINS = 6;

   // capture/compare module mode
   typedef enum logic [1:0] {
      CCP_OFF = 2'h0,
      CCP_CAPTURE = 2'h1,
      CCP_COMPARE = 2'h2,
      CCP_PWM = 2'h3
   } ccp_mode_t;

   // one-cycle event pulses from the surrounding peripherals
   typedef struct packed {
      logic timer0_rollover;
      logic conversion_done;
      logic capture_event;
      logic compare_match;
      logic comparator2_change;
      logic comparator1_change;
      logic timer2_match;
      logic timer1_overflow;
   } periph_events_t;

   // decoded software write strobes
   typedef struct packed {
      logic core_ctrl;
      logic periph_en;
      logic periph_flag;
      logic pin_mask;
      logic options;
   } reg_wr_t;
endpackage

// ---- hw/pin_sync.sv ----
// two-stage synchroniser with edge detection for pin inputs
`timescale 1ns/100ps
module pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] pin_i,
   output logic [WIDTH-1:0] level_o,
   output logic [WIDTH-1:0] rise_o,
   output logic [WIDTH-1:0] fall_o
);
   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;
   logic [WIDTH-1:0] prev_ff;
   // shifts in ones until meta, sync and history all hold real pin samples
   logic [2:0] fill_ff;

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_ff <= '0;
         sync_ff <= '0;
         prev_ff <= '0;
         fill_ff <= 3'h0;
      end else begin
         meta_ff <= pin_i;
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
         fill_ff <= {fill_ff[1:0], 1'b1};
      end
   end

   // no edges reported until the history stage holds a real sample
   assign level_o = sync_ff;
   assign rise_o = fill_ff[2] ? (sync_ff & ~prev_ff) : '0;
   assign fall_o = fill_ff[2] ? (~sync_ff & prev_ff) : '0;
endmodule

// ---- hw/sticky_flag.sv ----
// sticky flag bit: hardware set wins over software write
`timescale 1ns/100ps
module sticky_flag (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic set_i,
   input wire logic wr_i,
   input wire logic wr_val_i,
   output logic flag_o
);
   logic flag_ff;
   logic nxt_flag;

   assign nxt_flag = set_i ? 1'b1 : (wr_i ? wr_val_i : flag_ff);

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         flag_ff <= 1'b0;
      end else begin
         flag_ff <= nxt_flag;
      end
   end

   assign flag_o = flag_ff;
endmodule

// ---- hw/irq_enable_flag_bank.sv ----
// interrupt enable and flag bank with AHB-Lite register slave
`timescale 1ns/100ps
module irq_enable_flag_bank
   import irq_bank_pkg::*;
#(
   parameter bit REDUCED_VARIANT = 1'b0
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // AHB-Lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // pins
   input wire logic ext_irq_pin_i,
   input wire logic [5:0] port_a_pins_i,
   // peripheral events, same clock domain
   input wire periph_events_t events_i,
   input wire ccp_mode_t capcomp_mode_i,
   // request to the core
   output logic irq_o
);
   ////////////////////////////////////////////////////////////////////////////////
   // bus address phase capture
   logic wr_pend_ff;
   logic rd_pend_ff;
   logic [7:0] addr_ff;
   logic [31:0] rdata_ff;
   logic addr_phase;
   logic [31:0] rd_word;
   reg_wr_t wr;
   logic [7:0] wbyte;

   assign addr_phase = hsel_i & hready_i & htrans_i[1];

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_pend_ff <= 1'b0;
         rd_pend_ff <= 1'b0;
         addr_ff <= 8'h00;
      end else begin
         wr_pend_ff <= addr_phase & hwrite_i;
         rd_pend_ff <= addr_phase & ~hwrite_i;
         addr_ff <= addr_phase ? haddr_i[7:0] : addr_ff;
      end
   end

   function automatic logic hit(input logic [7:0] a, input logic [31:0] ofs);
      hit = (a == ofs[7:0]);
   endfunction

   assign wbyte = hwdata_i[7:0];
   assign wr.core_ctrl = wr_pend_ff & hit(addr_ff, CORE_CTRL_OFS);
   assign wr.periph_en = wr_pend_ff & hit(addr_ff, PERIPH_EN_OFS);
   assign wr.periph_flag = wr_pend_ff & hit(addr_ff, PERIPH_FLAG_OFS);
   assign wr.pin_mask = wr_pend_ff & hit(addr_ff, PIN_MASK_OFS);
   assign wr.options = wr_pend_ff & hit(addr_ff, OPTIONS_OFS);

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisation
   logic ext_rise;
   logic ext_fall;
   logic [5:0] port_rise;
   logic [5:0] port_fall;

   pin_sync #(.WIDTH(1)) u_ext_sync (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .pin_i(ext_irq_pin_i),
      .level_o(),
      .rise_o(ext_rise),
      .fall_o(ext_fall)
   );

   pin_sync #(.WIDTH(PORT_PINS)) u_port_sync (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .pin_i(port_a_pins_i),
      .level_o(),
      .rise_o(port_rise),
      .fall_o(port_fall)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // enables, mask and edge select
   logic [7:0] core_en_ff;
   logic [7:0] periph_en_ff;
   logic [5:0] pin_change_mask_ff;
   logic ext_edge_select_ff;
   logic [7:0] periph_impl;

   assign periph_impl = REDUCED_VARIANT ? PERIPH_IMPL_REDUCED : PERIPH_IMPL_FULL;

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         core_en_ff <= CORE_CTRL_RST;
         periph_en_ff <= PERIPH_RST;
         pin_change_mask_ff <= PIN_MASK_RST;
         ext_edge_select_ff <= EDGE_SEL_RST;
      end else begin
         if (wr.core_ctrl) begin
            core_en_ff <= wbyte & 8'hF8;
         end
         if (wr.periph_en) begin
            periph_en_ff <= wbyte & periph_impl;
         end
         if (wr.pin_mask) begin
            pin_change_mask_ff <= wbyte[5:0];
         end
         if (wr.options) begin
            ext_edge_select_ff <= wbyte[EDGE_SEL_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // flag set conditions, independent of any enable
   logic [7:0] core_set;
   logic [7:0] periph_set;
   logic ext_edge;
   logic port_change;
   logic capcomp_event;

   assign ext_edge = ext_edge_select_ff ? ext_rise : ext_fall;
   // only masked pins raise the change flag
   assign port_change = |((port_rise | port_fall) & pin_change_mask_ff);
   assign capcomp_event = (capcomp_mode_i == CCP_CAPTURE) ? events_i.capture_event :
                          (capcomp_mode_i == CCP_COMPARE) ? events_i.compare_match :
                          1'b0;

   assign core_set = {5'h00,
                      events_i.timer0_rollover,
                      ext_edge,
                      port_change};
   assign periph_set = {1'b0,
                        events_i.conversion_done,
                        capcomp_event,
                        events_i.comparator2_change,
                        events_i.comparator1_change,
                        1'b0,
                        events_i.timer2_match,
                        events_i.timer1_overflow} & periph_impl;

   logic [2:0] core_flags;
   logic [7:0] periph_flags;

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_core_flag
         sticky_flag u_flag (
            .sys_clk_i(sys_clk_i),
            .rst_i(rst_i),
            .set_i(core_set[gi]),
            .wr_i(wr.core_ctrl),
            .wr_val_i(wbyte[gi]),
            .flag_o(core_flags[gi])
         );
      end
      for (gi = 0; gi < 8; gi++) begin : g_periph_flag
         if (PERIPH_IMPL_FULL[gi] && (!REDUCED_VARIANT || PERIPH_IMPL_REDUCED[gi])) begin : g_impl
            sticky_flag u_flag (
               .sys_clk_i(sys_clk_i),
               .rst_i(rst_i),
               .set_i(periph_set[gi]),
               .wr_i(wr.periph_flag),
               .wr_val_i(wbyte[gi]),
               .flag_o(periph_flags[gi])
            );
         end else begin : g_unimpl
            assign periph_flags[gi] = 1'b0;
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // interrupt request
   logic [7:0] core_ctrl_rd;
   logic core_pending;
   logic periph_pending;
   logic irq_ff;

   assign core_ctrl_rd = {core_en_ff[7:3], core_flags};
   assign core_pending = (core_en_ff[T0_EN_BIT] & core_flags[T0_FLAG_BIT]) |
                         (core_en_ff[EXT_EN_BIT] & core_flags[EXT_FLAG_BIT]) |
                         (core_en_ff[PORT_EN_BIT] & core_flags[PORT_FLAG_BIT]);
   // a stale flag fires as soon as its enable is written
   assign periph_pending = core_en_ff[GROUP_BIT] & |(periph_en_ff & periph_flags);

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= core_en_ff[GLOBAL_BIT] & (core_pending | periph_pending);
      end
   end

   assign irq_o = irq_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // read data
   assign rd_word = hit(addr_ff, CORE_CTRL_OFS) ? {24'h000000, core_ctrl_rd} :
                    hit(addr_ff, PERIPH_EN_OFS) ? {24'h000000, periph_en_ff} :
                    hit(addr_ff, PERIPH_FLAG_OFS) ? {24'h000000, periph_flags} :
                    hit(addr_ff, PIN_MASK_OFS) ? {26'h0000000, pin_change_mask_ff} :
                    hit(addr_ff, OPTIONS_OFS) ? {31'h00000000, ext_edge_select_ff} :
                    32'h00000000;

   assign rdata_ff = rd_word;
   assign hrdata_o = rd_pend_ff ? rdata_ff : 32'h00000000;
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;
endmodule

// ---- test/irq_bank_chk.sv ----
// assertion checker for the interrupt enable and flag bank
`timescale 1ns/100ps
module irq_bank_chk
   import irq_bank_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   input wire logic [31:0] hrdata_o,
   input wire logic ext_irq_pin_i,
   input wire periph_events_t events_i,
   input wire ccp_mode_t capcomp_mode_i,
   input wire logic irq_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   logic [5:0] idx_ff;
   logic wr_ff;
   logic rd_ff;
   logic [7:0] sh_ff [5];
   wire req = hsel_i & hready_i & htrans_i[1];
   wire glb_en = sh_ff[0][7];
   wire grp_en = sh_ff[0][6];
   wire [2:0] core_en = sh_ff[0][5:3];
   wire [7:0] pe = sh_ff[1];
   wire pe_hit = |({events_i.conversion_done, events_i.comparator2_change,
      events_i.comparator1_change, events_i.timer2_match, events_i.timer1_overflow}
      & {pe[6], pe[4], pe[3], pe[1], pe[0]});
   wire cc_hit = pe[5] & ((events_i.capture_event & (capcomp_mode_i == CCP_CAPTURE))
      | (events_i.compare_match & (capcomp_mode_i == CCP_COMPARE)));
   ////////////////////////////////////////
   // shadow of what software wrote, updated at the edge where the write lands
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_ff <= 1'b0;
         rd_ff <= 1'b0;
         idx_ff <= 6'h00;
         sh_ff <= '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
      end else begin
         wr_ff <= req & hwrite_i;
         rd_ff <= req & ~hwrite_i;
         idx_ff <= haddr_i[7:2];
         if (wr_ff && idx_ff < 6'h05) begin
            sh_ff[idx_ff[2:0]] <= hwdata_i[7:0];
         end
      end
   end
   property p_glb_off;
      !$past(glb_en) |-> !irq_o;
   endproperty
   a_glb_off: assert property (p_glb_off) else $error("request while globally off");
   property p_grp_off;
      !$past(grp_en) && $past(core_en) == 3'h0 |-> !irq_o;
   endproperty
   a_grp_off: assert property (p_grp_off) else $error("peripheral request ungated");
   property p_t0;
      events_i.timer0_rollover && glb_en && sh_ff[0][5] |-> ##2 irq_o;
   endproperty
   a_t0: assert property (p_t0) else $error("timer0 rollover not requested");
   property p_periph;
      pe_hit && glb_en && grp_en |-> ##2 irq_o;
   endproperty
   a_periph: assert property (p_periph) else $error("peripheral event lost");
   property p_capcomp;
      cc_hit && glb_en && grp_en |-> ##2 irq_o;
   endproperty
   a_capcomp: assert property (p_capcomp) else $error("capture event lost");
   property p_hold;
      $fell(irq_o) |-> $past(wr_ff, 2);
   endproperty
   a_hold: assert property (p_hold) else $error("request dropped without write");
   property p_ext;
      $rose(ext_irq_pin_i) && sh_ff[4][0] && glb_en && sh_ff[0][4] |-> ##[2:6] irq_o;
   endproperty
   a_ext: assert property (p_ext) else $error("rising pin edge lost");
   property p_rsvd;
      rd_ff && (idx_ff == 6'h01 || idx_ff == 6'h02)
         |-> hrdata_o[31:8] == 24'h0 && !hrdata_o[7] && !hrdata_o[2];
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("unused bit reads one");
   c_irq: cover property ($rose(irq_o));
   c_ext: cover property ($rose(ext_irq_pin_i) && glb_en);
   c_rd: cover property (rd_ff && idx_ff == 6'h01);
endmodule
bind irq_enable_flag_bank irq_bank_chk i_chk (.sys_clk_i, .rst_i, .hsel_i, .haddr_i,
   .htrans_i, .hwrite_i, .hwdata_i, .hready_i, .hrdata_o, .ext_irq_pin_i, .events_i,
   .capcomp_mode_i, .irq_o);

// ---- test/core_model.sv ----
// processor core model: software bus master and interrupt request sense
`timescale 1ns/100ps
module core_model (
   input wire logic sys_clk_i,
   input wire logic hready_i,
   input wire logic [31:0] hrdata_i,
   input wire logic irq_i,
   output logic hsel_o = 1'b0,
   output logic [31:0] haddr_o = 32'h0,
   output logic [1:0] htrans_o = 2'h0,
   output logic hwrite_o = 1'b0,
   output logic [2:0] hsize_o = 3'h2,
   output logic [31:0] hwdata_o = 32'h0
);
   int irq_seen = 0;
   logic irq_q = 1'b0;
   logic tmo = 1'b0;
   // counts each time the core would vector
   always @(posedge sys_clk_i) begin
      irq_q <= irq_i;
      if (irq_i === 1'b1 && irq_q !== 1'b1) begin
         irq_seen <= irq_seen + 1;
      end
   end
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (hready_i !== 1'b1 && n < 40);
      if (hready_i !== 1'b1) begin
         tmo = 1'b1;
      end
   endtask
   task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d,
      output logic [31:0] q);
      hsel_o <= 1'b1;
      haddr_o <= a;
      htrans_o <= 2'h2;
      hwrite_o <= w;
      wait_rdy();
      hsel_o <= 1'b0;
      htrans_o <= 2'h0;
      hwdata_o <= {24'h0, d};
      wait_rdy();
      q = hrdata_i;
   endtask
endmodule

// ---- test/test_mcu_interrupt_enable_flag_bank.sv ----
// self-checking bench for the interrupt enable and flag bank
`timescale 1ns/100ps
module test_mcu_interrupt_enable_flag_bank import irq_bank_pkg::*;;
   localparam logic [31:0] NO_REG = 32'h0000_0020;
   logic sys_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ext_pin = 1'b0;
   logic [5:0] port_pins = 6'h00;
   periph_events_t ev = '0;
   ccp_mode_t mode = CCP_OFF;
   wire hsel, hwrite, hready, hresp, irq;
   wire [31:0] haddr, hwdata, hrdata;
   wire [1:0] htrans;
   wire [2:0] hsize;
   wire [31:0] irq_w = {31'h0, irq};
   int bad_count = 0;
   int compares = 0;
   logic [31:0] q;
   always #12.5 sys_clk_i = ~sys_clk_i;
   irq_enable_flag_bank i_dut (.sys_clk_i, .rst_i, .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
      .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
      .ext_irq_pin_i(ext_pin), .port_a_pins_i(port_pins), .events_i(ev),
      .capcomp_mode_i(mode), .irq_o(irq));
   core_model i_core (.sys_clk_i, .hready_i(hready), .hrdata_i(hrdata), .irq_i(irq),
      .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite),
      .hsize_o(hsize), .hwdata_o(hwdata));
   ////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      i_core.xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] exp);
      i_core.xfer(1'b0, a, 8'h00, q);
      chk(q, exp);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask
   // one-cycle event pulse, then time for the request to settle
   task automatic pulse(input logic [7:0] m);
      ev <= periph_events_t'(m);
      cyc(1);
      ev <= '0;
      cyc(3);
   endtask
   task automatic t_reset();
      rd(CORE_CTRL_OFS, 32'h0);
      rd(PERIPH_EN_OFS, 32'h0);
      rd(PERIPH_FLAG_OFS, 32'h0);
      rd(OPTIONS_OFS, 32'h1);
      rd(NO_REG, 32'h0);
      chk({31'h0, hresp}, 32'h0);
      wr(CORE_CTRL_OFS, 8'hF8);
      rd(CORE_CTRL_OFS, 32'hF8);
      wr(PERIPH_EN_OFS, 8'hFF);
      rd(PERIPH_EN_OFS, 32'h7B);
      wr(NO_REG, 8'hFF);
      rd(NO_REG, 32'h0);
      wr(CORE_CTRL_OFS, 8'h00);
      wr(PERIPH_EN_OFS, 8'h00);
      $display("t_reset done");
   endtask
   task automatic t_flags();
      mode <= CCP_CAPTURE;
      pulse(8'hEF);
      chk(irq_w, 32'h0);
      rd(CORE_CTRL_OFS, 32'h04);
      rd(PERIPH_FLAG_OFS, 32'h7B);
      wr(PERIPH_FLAG_OFS, 8'h00);
      mode <= CCP_COMPARE;
      pulse(8'h10);
      rd(PERIPH_FLAG_OFS, 32'h20);
      wr(PERIPH_FLAG_OFS, 8'h00);
      mode <= CCP_PWM;
      pulse(8'h30);
      rd(PERIPH_FLAG_OFS, 32'h0);
      wr(CORE_CTRL_OFS, 8'h00);
      $display("t_flags done");
   endtask
   task automatic t_irq();
      wr(PERIPH_FLAG_OFS, 8'h00);
      wr(PERIPH_EN_OFS, 8'h21);
      wr(CORE_CTRL_OFS, 8'h80);
      pulse(8'h01);
      chk(irq_w, 32'h0);
      wr(CORE_CTRL_OFS, 8'hC0);
      cyc(2);
      chk(irq_w, 32'h1);
      wr(CORE_CTRL_OFS, 8'h40);
      cyc(2);
      chk(irq_w, 32'h0);
      wr(CORE_CTRL_OFS, 8'hC0);
      wr(PERIPH_FLAG_OFS, 8'h00);
      cyc(2);
      chk(irq_w, 32'h0);
      mode <= CCP_CAPTURE;
      pulse(8'h21);
      chk(irq_w, 32'h1);
      wr(PERIPH_FLAG_OFS, 8'h00);
      wr(CORE_CTRL_OFS, 8'hA0);
      pulse(8'h80);
      chk(irq_w, 32'h1);
      chk(i_core.irq_seen, 32'h4);
      wr(CORE_CTRL_OFS, 8'h00);
      $display("t_irq done");
   endtask
   task automatic t_pins();
      wr(CORE_CTRL_OFS, 8'h90);
      ext_pin <= 1'b1;
      cyc(8);
      chk(irq_w, 32'h1);
      wr(OPTIONS_OFS, 8'h00);
      wr(CORE_CTRL_OFS, 8'h90);
      ext_pin <= 1'b0;
      cyc(8);
      rd(CORE_CTRL_OFS, 32'h92);
      wr(CORE_CTRL_OFS, 8'h00);
      ext_pin <= 1'b1;
      cyc(8);
      rd(CORE_CTRL_OFS, 32'h0);
      wr(PIN_MASK_OFS, 8'h04);
      wr(CORE_CTRL_OFS, 8'h88);
      port_pins <= 6'h01;
      cyc(8);
      chk(irq_w, 32'h0);
      port_pins <= 6'h05;
      cyc(8);
      chk(irq_w, 32'h1);
      rd(CORE_CTRL_OFS, 32'h89);
      wr(CORE_CTRL_OFS, 8'h00);
      $display("t_pins done");
   endtask
   // mid-run reset with the pin held high: no false edge may follow release
   task automatic t_rst();
      rst_i <= 1'b1;
      cyc(10);
      rst_i <= 1'b0;
      cyc(8);
      rd(CORE_CTRL_OFS, 32'h0);
      rd(PIN_MASK_OFS, 32'h0);
      rd(OPTIONS_OFS, 32'h1);
      $display("t_rst done");
   endtask
   task automatic stop_test();
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   always @(posedge i_core.tmo) begin
      bad_count++;
      stop_test();
   end
   initial begin
      cyc(10);
      rst_i <= 1'b0;
      cyc(4);
      t_reset();
      t_flags();
      t_irq();
      t_pins();
      t_rst();
      stop_test();
   end
endmodule
